/* design/eqcl_biquad.sv */
// Purpose: one direct-form biquad section on a single sample stream
// Assumes: Q1.14 coefficients, b1 and b2 are feedback terms subtracted
// Notes: result saturates to 16 bits
`timescale 1ns/100ps
module eqcl_biquad #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // sample stream
  input wire logic sampleStb,
  input wire logic signed [W-1:0] xIn,
  output logic signed [W-1:0] yOut,
  // coefficients
  input wire logic signed [W-1:0] a0,
  input wire logic signed [W-1:0] a1,
  input wire logic signed [W-1:0] a2,
  input wire logic signed [W-1:0] b1,
  input wire logic signed [W-1:0] b2
);
  typedef struct packed {
    logic signed [W-1:0] x1;
    logic signed [W-1:0] x2;
    logic signed [W-1:0] y1;
    logic signed [W-1:0] y2;
  } eqcl_bq_state_t;
  eqcl_bq_state_t st_r;
  eqcl_bq_state_t st_nxt;
  logic signed [2*W+3:0] acc;
  logic signed [2*W+3:0] shifted;
  logic signed [W-1:0] ySat;

  // multiply-accumulate and saturation
  always_comb begin
    // operands widened first so no product is cut to W bits
    acc = (2*W+4)'(a0) * (2*W+4)'(xIn) + (2*W+4)'(a1) * (2*W+4)'(st_r.x1)
        + (2*W+4)'(a2) * (2*W+4)'(st_r.x2) - (2*W+4)'(b1) * (2*W+4)'(st_r.y1)
        - (2*W+4)'(b2) * (2*W+4)'(st_r.y2);
    shifted = acc >>> (W - 2);
    if (shifted > (2*W+4)'(2**(W-1) - 1)) begin
      ySat = {1'b0, {(W-1){1'b1}}};
    end else if (shifted < -(2*W+4)'(2**(W-1))) begin
      ySat = {1'b1, {(W-1){1'b0}}};
    end else begin
      ySat = shifted[W-1:0];
    end
    st_nxt = st_r;
    if (sampleStb) begin
      st_nxt.x1 = xIn;
      st_nxt.x2 = st_r.x1;
      st_nxt.y1 = ySat;
      st_nxt.y2 = st_r.y1;
    end
  end

  // history registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign yOut = st_r.y1;
endmodule // eqcl_biquad

/* design/eqcl_equalizer_coef_loader.sv */
// Purpose: equalizer control register, coefficient memory and biquad cascade
// Assumes: APB slave, samples arrive with a one-cycle strobe
// Notes: one section per stage and channel, stepped one per cycle after a take
`timescale 1ns/100ps

// Notes on behaviour
// RQ1 - control register resets to 0x8080: bypassed, symmetry on
// RQ2 - bypass bit 15 set passes audio unchanged; clear applies filtering
// RQ3 - coefficient port writes land in memory only while bypassed
// RQ4 - port write stores at the pointer; read returns the word there
// RQ5 - seven biquads of five slots from a2 at 0x19 up to 0x3B
// RQ6 - with symmetry set, a write goes to left and right together
// RQ7 - with symmetry clear, left and right sets are written separately
// RQ8 - side-select bit 6 picks left (0) or right (1) block
// RQ9 - coefficients are 16-bit words, bit 15 most significant
// RQ10 - control register reads back, unused bits read zero
// RQ11 - software loads all coefficients while bypassed, then enables
// RQ12 - enabled, each channel runs through seven cascaded sections
module eqcl_equalizer_coef_loader #(
  parameter int NUM_BQ = eqcl_pkg::NUM_BIQUAD
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // audio
  input wire logic sampleValid,
  input wire eqcl_pkg::eqcl_sample_t sampleIn,
  output logic sampleOutValid,
  output eqcl_pkg::eqcl_sample_t sampleOut,
  output logic eqBypass
);
  localparam int NSLOT = NUM_BQ * eqcl_pkg::NUM_SLOT;
  // stage counter wide enough for the last section index
  localparam int STAGE_W = (NUM_BQ > 1) ? $clog2(NUM_BQ) : 1;

  // audio sequencer: wait, step the cascade, present the result
  typedef enum logic [1:0] {
    AUD_IDLE = 2'b00,
    AUD_RUN = 2'b01,
    AUD_DONE = 2'b10
  } eqcl_aud_t;

  typedef struct packed {
    logic [15:0] setup;
    logic [31:0] rdata;
    logic ready;
    logic err;
    eqcl_aud_t aud;
    logic [STAGE_W-1:0] stage;
    logic outValid;
    eqcl_pkg::eqcl_sample_t out;
  } eqcl_state_t;

  eqcl_state_t st_r;
  eqcl_state_t st_nxt;
  logic [15:0] coefL [NSLOT];
  logic [15:0] coefR [NSLOT];

  // slot index from pointer, valid flag when in range
  function automatic logic [6:0] slotOf(input logic [5:0] ptr);
    logic [5:0] d;
    d = ptr - eqcl_pkg::PTR_FIRST;
    if (ptr >= eqcl_pkg::PTR_FIRST && ptr <= eqcl_pkg::PTR_LAST) begin // RQ5
      slotOf = {1'b1, d};
    end else begin
      slotOf = 7'h00;
    end
  endfunction

  // memory slot of one coefficient of one section
  function automatic logic [5:0] coefIdx(input int sec, input int ofs);
    coefIdx = 6'(sec * eqcl_pkg::NUM_SLOT + ofs);
  endfunction

  logic setupSel;
  logic coefSel;
  logic accessPhase;
  logic [6:0] slot;
  logic [15:0] portWord;
  logic coefWrite;
  logic bypassOn;
  logic symOn;
  logic sideRight;

  assign bypassOn = st_r.setup[eqcl_pkg::BYPASS_BIT];
  assign symOn = st_r.setup[eqcl_pkg::SYM_BIT];
  assign sideRight = st_r.setup[eqcl_pkg::SIDE_BIT];
  assign setupSel = paddr == eqcl_pkg::SETUP_ADDR;
  assign coefSel = paddr == eqcl_pkg::COEF_ADDR;
  assign accessPhase = psel && penable && !st_r.ready;
  assign slot = slotOf(st_r.setup[eqcl_pkg::PTR_W-1:0]); // RQ4
  // gated on bypass: writes while filtering are dropped
  assign coefWrite = accessPhase && pwrite && coefSel && bypassOn && slot[6]; // RQ3

  // read data: side select picks the block the pointer reaches
  always_comb begin
    portWord = 16'h0000;
    if (slot[6]) begin
      portWord = sideRight ? coefR[slot[5:0]] : coefL[slot[5:0]]; // RQ8 RQ4
    end
  end

  // coefficient memories, one array per channel
  always_ff @(posedge core_clk) begin
    if (coefWrite) begin
      if (symOn) begin
        coefL[slot[5:0]] <= pwdata[15:0]; // RQ6 RQ9
        coefR[slot[5:0]] <= pwdata[15:0]; // RQ6
      end else if (sideRight) begin
        coefR[slot[5:0]] <= pwdata[15:0]; // RQ7
      end else begin
        coefL[slot[5:0]] <= pwdata[15:0]; // RQ7
      end
    end
  end

  // cascade: each section keeps its own history, so no state is shared
  // section 0 steps on the taking edge, section k on run stage k
  logic takeRun;
  logic [15:0] yL [NUM_BQ];
  logic [15:0] yR [NUM_BQ];
  assign takeRun = st_r.aud == AUD_IDLE && sampleValid && !bypassOn; // RQ2

  for (genvar k = 0; k < NUM_BQ; k++) begin : g_sec
    logic stb;
    logic [15:0] xL;
    logic [15:0] xR;
    // first section reads the input, the rest their predecessor's output
    if (k == 0) begin : g_head
      assign stb = takeRun;
      assign xL = sampleIn.left;
      assign xR = sampleIn.right;
    end else begin : g_tail
      assign stb = st_r.aud == AUD_RUN && st_r.stage == STAGE_W'(k); // RQ12
      assign xL = yL[k-1]; // RQ12
      assign xR = yR[k-1];
    end

    // left channel section, coefficient order a2 a1 a0 b2 b1
    eqcl_biquad #(.W(eqcl_pkg::DATA_W)) uBqL (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sampleStb(stb),
      .xIn(xL),
      .yOut(yL[k]),
      .a0(coefL[coefIdx(k, eqcl_pkg::SLOT_A0)]),
      .a1(coefL[coefIdx(k, eqcl_pkg::SLOT_A1)]),
      .a2(coefL[coefIdx(k, eqcl_pkg::SLOT_A2)]),
      .b1(coefL[coefIdx(k, eqcl_pkg::SLOT_B1)]),
      .b2(coefL[coefIdx(k, eqcl_pkg::SLOT_B2)])
    );

    // right channel section, right coefficient block
    eqcl_biquad #(.W(eqcl_pkg::DATA_W)) uBqR (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sampleStb(stb),
      .xIn(xR),
      .yOut(yR[k]),
      .a0(coefR[coefIdx(k, eqcl_pkg::SLOT_A0)]),
      .a1(coefR[coefIdx(k, eqcl_pkg::SLOT_A1)]),
      .a2(coefR[coefIdx(k, eqcl_pkg::SLOT_A2)]),
      .b1(coefR[coefIdx(k, eqcl_pkg::SLOT_B1)]),
      .b2(coefR[coefIdx(k, eqcl_pkg::SLOT_B2)])
    );
  end

  // next-state logic for bus and audio path
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.outValid = 1'b0;
    if (accessPhase) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (setupSel) begin
        if (pwrite) begin
          st_nxt.setup = pwdata[15:0] & eqcl_pkg::SETUP_MASK; // RQ10
        end else begin
          st_nxt.rdata = {16'h0000, st_r.setup}; // RQ10
        end
      end else if (coefSel) begin
        if (!pwrite) begin
          st_nxt.rdata = {16'h0000, portWord}; // RQ4
        end
      end else begin
        st_nxt.err = 1'b1;
      end
    end
    // audio sequencer; samples arriving outside idle are dropped
    unique case (st_r.aud)
      AUD_IDLE: begin
        if (sampleValid && bypassOn) begin
          st_nxt.outValid = 1'b1;
          st_nxt.out = sampleIn; // RQ2
        end else if (takeRun) begin
          st_nxt.aud = AUD_RUN; // RQ2
          st_nxt.stage = STAGE_W'(1);
        end
      end
      AUD_RUN: begin
        // the section of this stage steps on this edge
        if (st_r.stage == STAGE_W'(NUM_BQ - 1)) begin
          st_nxt.aud = AUD_DONE;
        end else begin
          st_nxt.stage = st_r.stage + STAGE_W'(1); // RQ12
        end
      end
      AUD_DONE: begin
        // last section output settled on the previous edge
        st_nxt.aud = AUD_IDLE;
        st_nxt.outValid = 1'b1;
        st_nxt.out = '{left: yL[NUM_BQ-1], right: yR[NUM_BQ-1]}; // RQ12
      end
      default: begin
        st_nxt.aud = AUD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.setup <= eqcl_pkg::SETUP_RESET; // RQ1
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign sampleOutValid = st_r.outValid;
  assign sampleOut = st_r.out;
  assign eqBypass = bypassOn;
endmodule // eqcl_equalizer_coef_loader

/* design/eqcl_pkg.sv */
// Purpose: shared constants and carriers for the equalizer coefficient loader
// Assumes: APB with 32-bit data, 16-bit registers in the low half of the word
// Notes: printed offset 0x62 is not a multiple of four, so 0x60 and 0x62 are indices
package eqcl_pkg;
  localparam int DATA_W = 16;
  localparam int PTR_W = 6;
  localparam int NUM_BIQUAD = 7;
  localparam int NUM_SLOT = 5;
  // register indices and byte addresses
  localparam logic [7:0] SETUP_IDX = 8'h60;
  localparam logic [7:0] COEF_IDX = 8'h62;
  localparam logic [11:0] SETUP_ADDR = 12'h180;
  localparam logic [11:0] COEF_ADDR = 12'h188;
  // setup register fields
  localparam int BYPASS_BIT = 15;
  localparam int SYM_BIT = 7;
  localparam int SIDE_BIT = 6;
  localparam logic [15:0] SETUP_RESET = 16'h8080;
  localparam logic [15:0] SETUP_MASK = 16'h80FF;
  // first a2 slot of biquad 0, last slot of biquad 6
  localparam logic [5:0] PTR_FIRST = 6'h19;
  localparam logic [5:0] PTR_LAST = 6'h3B;
  localparam logic [5:0] NUM_COEF = 6'h23;
  // coefficient order inside the five slots of one section
  localparam int SLOT_A2 = 0;
  localparam int SLOT_A1 = 1;
  localparam int SLOT_A0 = 2;
  localparam int SLOT_B2 = 3;
  localparam int SLOT_B1 = 4;
  // one coefficient access request
  typedef struct packed {
    logic wr;
    logic side;
    logic [5:0] index;
    logic [15:0] data;
  } eqcl_coef_req_t;
  // one audio sample pair
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } eqcl_sample_t;
endpackage

/* test/eqcl_loader_sva.sv */
// Purpose: port checks for the coefficient loader
// Assumes: one wait state on apb, registered outputs
// Notes: attached to every loader instance by bind
`timescale 1ns/100ps
module eqcl_loader_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // audio
  input wire logic sampleValid,
  input wire eqcl_pkg::eqcl_sample_t sampleIn,
  input wire logic sampleOutValid,
  input wire eqcl_pkg::eqcl_sample_t sampleOut,
  input wire logic eqBypass
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // access phase then its answer
  sequence s_acc;
    psel && penable && !pready ##1 pready;
  endsequence
  sequence s_setw;
    s_acc ##0 (pwrite && paddr == eqcl_pkg::SETUP_ADDR);
  endsequence
  property p_ans; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_inacc; pready |-> psel && penable; endproperty
  property p_err;
    pready |-> pslverr == !(paddr == eqcl_pkg::SETUP_ADDR || paddr == eqcl_pkg::COEF_ADDR);
  endproperty
  property p_rd;
    pready && !pwrite && paddr == eqcl_pkg::SETUP_ADDR
      |-> prdata[31:16] == 16'h0 && (prdata[15:0] & ~eqcl_pkg::SETUP_MASK) == 16'h0;
  endproperty
  property p_wr; s_setw |=> eqBypass == $past(pwdata[15]); endproperty
  property p_byp;
    sampleValid && eqBypass |=> sampleOutValid && sampleOut == $past(sampleIn);
  endproperty
  property p_eq; sampleValid && !eqBypass |-> ##8 sampleOutValid; endproperty
  property p_ov; sampleOutValid |=> !sampleOutValid; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle into access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_inacc: assert property (p_inacc) else $error("ready outside access phase");
  a_err: assert property (p_err) else $error("error flag wrong for address");
  a_rd: assert property (p_rd) else $error("unused setup bits not zero");
  a_wr: assert property (p_wr) else $error("bypass does not follow bit 15");
  a_byp: assert property (p_byp) else $error("bypassed sample changed");
  a_eq: assert property (p_eq) else $error("cascade result late or missing");
  a_ov: assert property (p_ov) else $error("output valid longer than one cycle");
endmodule // eqcl_loader_sva

bind eqcl_equalizer_coef_loader eqcl_loader_sva eqcl_loader_sva_inst (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleValid(sampleValid), .sampleIn(sampleIn), .sampleOutValid(sampleOutValid),
  .sampleOut(sampleOut), .eqBypass(eqBypass)
);

/* test/testbench.sv */
// Purpose: register, coefficient and audio checks of the loader
// Assumes: apb answers after one wait state, cascade result 8 cycles on
// Notes: all coefficients are loaded before any audio is sent
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic sampleValid = 1'b0;
  eqcl_pkg::eqcl_sample_t sampleIn = 32'h0;
  eqcl_pkg::eqcl_sample_t sampleOut;
  logic sampleOutValid;
  logic eqBypass;
  int n_fail = 0;
  int samples_checked = 0;
  // device under test
  eqcl_equalizer_coef_loader eqcl_equalizer_coef_loader_inst (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .sampleOutValid(sampleOutValid),
    .sampleOut(sampleOut), .eqBypass(eqBypass)
  );
  // 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task setp(input logic byp, input logic coef_symmetry, input logic side, input logic [5:0] p);
    apb(1'b1, eqcl_pkg::SETUP_ADDR, {16'h0, byp, 7'h0, coef_symmetry, side, p});
  endtask
  // one sample pair, result checked for value and latency
  task snd(input logic [31:0] x, input logic [31:0] exp, input int lat);
    int n;
    n = 0;
    sampleIn <= x;
    sampleValid <= 1'b1;
    @(posedge core_clk);
    sampleValid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sampleOutValid !== 1'b1 && n < 20);
    chk(32'(n), 32'(lat));
    chk(sampleOut, exp);
    repeat (10) @(posedge core_clk);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    chk({31'h0, eqBypass}, 32'h1);
    apb(1'b0, eqcl_pkg::SETUP_ADDR, 32'h0);
    chk(rd, 32'h8080);
    apb(1'b1, eqcl_pkg::SETUP_ADDR, 32'hFFFF);
    apb(1'b0, eqcl_pkg::SETUP_ADDR, 32'h0);
    chk(rd, 32'h80FF);
    $display("setup register test done");
    for (int i = 0; i < 35; i++) begin
      setp(1'b1, 1'b1, 1'b0, eqcl_pkg::PTR_FIRST + 6'(i));
      apb(1'b1, eqcl_pkg::COEF_ADDR, (i % 5 == 2) ? 32'h2000 : 32'h0);
    end
    setp(1'b1, 1'b1, 1'b1, 6'h39);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h2000);
    for (int i = 0; i < 7; i++) begin
      setp(1'b1, 1'b0, 1'b1, 6'h1B + 6'(5 * i));
      apb(1'b1, eqcl_pkg::COEF_ADDR, 32'h4000);
    end
    setp(1'b1, 1'b0, 1'b0, 6'h1B);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h2000);
    setp(1'b1, 1'b0, 1'b1, 6'h1B);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h4000);
    setp(1'b1, 1'b0, 1'b0, 6'h19);
    apb(1'b1, eqcl_pkg::COEF_ADDR, 32'h8001);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h8001);
    apb(1'b1, eqcl_pkg::COEF_ADDR, 32'h0);
    setp(1'b1, 1'b1, 1'b0, 6'h18);
    apb(1'b1, eqcl_pkg::COEF_ADDR, 32'h1234);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("coefficient test done");
    snd(32'h4000C123, 32'h4000C123, 1);
    setp(1'b0, 1'b0, 1'b0, 6'h3B);
    chk({31'h0, eqBypass}, 32'h0);
    apb(1'b1, eqcl_pkg::COEF_ADDR, 32'hA5C3);
    snd(32'h4000C123, 32'h0080C123, 8);
    apb(1'b0, eqcl_pkg::COEF_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("audio test done");
    end_of_test;
  end
  // watchdog
  initial begin
    #1000000;
    n_fail++;
    end_of_test;
  end
endmodule // testbench
